// file: rtl/cmtx_consts.vh
// cmtx_consts.vh: offsets, field positions, reset values and counts of the
// can mode and transmit mailbox block.
// assumes it is included by its bare name from the rtl files.
`ifndef CMTX_CONSTS_VH
`define CMTX_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define CMTX_MCR_OFS     8'h00
`define CMTX_MSR_OFS     8'h01
`define CMTX_TSR_OFS     8'h02
`define CMTX_MB0_CS_OFS  8'h03
`define CMTX_MB1_CS_OFS  8'h04
`define CMTX_IER_OFS     8'h05
`define CMTX_DGR_OFS     8'h06
`define CMTX_MB0_BASE    8'h10
`define CMTX_MB1_BASE    8'h20
`define CMTX_MB_LAST     4'ha

////////////////////////////////////////////////////////////////////////////////
// master control fields
`define CMTX_MCR_INIT_REQUEST_BIT    0
`define CMTX_MCR_SLRQ    1
`define CMTX_MCR_TRANSMIT_FIFO_PRIORITY_BIT    2
`define CMTX_MCR_NO_AUTO_RETRANSMIT_BIT    4
`define CMTX_MCR_AUTO_WAKEUP_BIT    5
`define CMTX_MCR_RST     8'h02
// master status fields
`define CMTX_MSR_INIT_ACKNOWLEDGE_BIT    0
`define CMTX_MSR_SLEEP_ACKNOWLEDGE_BIT    1
`define CMTX_MSR_WKUI    3
// mailbox control fields
`define CMTX_CS_TRANSMIT_REQUEST_BIT     0
`define CMTX_CS_ABORT_REQUEST_BIT     1
// per mailbox flags in the transmit status register, mailbox n at 4*n
`define CMTX_TSR_REQUEST_COMPLETE_FLAG    0
`define CMTX_TSR_TRANSMIT_OK_FLAG    1
`define CMTX_TSR_ARBITRATION_LOST_FLAG    2
`define CMTX_TSR_TRANSMIT_ERROR_FLAG    3
// interrupt enable and diagnostic fields
`define CMTX_IER_WAKEUP_INTERRUPT_ENABLE   0
`define CMTX_DGR_SILENT_SELECT_BIT    0
`define CMTX_DGR_LOOPBACK_SELECT_BIT    1

////////////////////////////////////////////////////////////////////////////////
// mailbox states
`define CMTX_MB_EMPTY    2'h0
`define CMTX_MB_PEND     2'h1
`define CMTX_MB_SCHED    2'h2
`define CMTX_MB_XMIT     2'h3
// recessive bits that mark an idle bus
`define CMTX_IDLE_BITS   11

`endif

// file: rtl/cmtx_sync3.v
// cmtx_sync3.v: three stage input synchroniser with agreement filter.
// assumes an asynchronous level input; output moves once stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none

module cmtx_sync3 #(
	parameter RST_VAL = 1'b1
) (
	// clock, reset, enable
	input  wire i_clk_sys,
	input  wire i_rstn,
	input  wire i_ce,
	// level in and filtered level out
	input  wire i_async,
	output reg  o_level
);

	reg s1_q;
	reg s2_q;
	reg s3_q;

	// shift chain; stage 1 only feeds stage 2
	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			s1_q    <= RST_VAL;
			s2_q    <= RST_VAL;
			s3_q    <= RST_VAL;
			o_level <= RST_VAL;
		end else if (i_ce) begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				o_level <= s3_q;
			end
		end
	end

endmodule // cmtx_sync3
`default_nettype wire

// file: rtl/cmtx_idle_det.v
// cmtx_idle_det.v: counts consecutive recessive bits at bit ticks.
// assumes a one-cycle bit tick from the bit timing logic.
`timescale 1ns/1ps
`default_nettype none
`include "cmtx_consts.vh"

module cmtx_idle_det #(
	parameter IDLE_BITS = `CMTX_IDLE_BITS
) (
	// clock, reset, enable
	input  wire i_clk_sys,
	input  wire i_rstn,
	input  wire i_ce,
	// restart, bit tick and sampled bus level
	input  wire i_clr,
	input  wire i_tick,
	input  wire i_bit,
	// bus seen idle
	output reg  o_idle
);

	reg [3:0] cnt_q;

	// any dominant bit restarts the count
	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			cnt_q  <= 4'h0;
			o_idle <= 1'b0;
		end else if (i_ce) begin
			if (i_clr || (i_tick && !i_bit)) begin
				cnt_q  <= 4'h0;
				o_idle <= 1'b0;
			end else if (i_tick && !o_idle) begin
				cnt_q  <= cnt_q + 4'h1;
				o_idle <= (cnt_q == IDLE_BITS[3:0] - 4'h1);
			end
		end
	end

endmodule // cmtx_idle_det
`default_nettype wire

// file: rtl/cmtx_ctrl.v
// cmtx_ctrl.v: operating modes, test modes and two transmit mailboxes
// of a can controller, with register port and scheduler.
// assumes a protocol core that sends frames on request and reports results,
// and a bit timing block that gives one tick per bit time.
//
// Overview of operation
// RL1 - after reset the controller sits in sleep mode.
// RL2 - request bits ask for init or sleep; acknowledge bits confirm; none means normal.
// RL3 - eleven recessive bits must be seen before joining the bus.
// RL4 - clearing init request leaves init; acknowledge clears only once left.
// RL5 - in init no transfers happen and transmit pin stays recessive.
// RL6 - entering init changes no configuration register.
// RL7 - software sets filters only when inactive, scale and mode only in init.
// RL8 - in sleep status bits freeze; init request during sleep stays unacknowledged.
// RL9 - bus activity in sleep clears sleep request when auto wake-up set.
// RL10 - wake-up interrupt raised on bus activity when enabled, even with auto wake.
// RL11 - after sleep request clears, leave sleep after sync, then clear acknowledge.
// RL12 - test bits are set in init; then device runs in normal mode.
// RL13 - silent: only recessive sent, no transmission, dominant fed back internally.
// RL14 - loop-back: transmit fed to receive, pin ignored, ack errors ignored, pin driven.
// RL15 - loop-back plus silent: receive pin cut off and transmit pin recessive.
// RL16 - software fills an empty mailbox then requests; non-empty mailbox refuses writes.
// RL17 - mailbox goes pending, scheduled, transmit; success empties and flags complete.
// RL18 - failure sets arbitration lost and/or transmit error flags.
// RL19 - identifier priority sends lowest identifier first, ties to mailbox zero.
// RL20 - fifo priority bit schedules mailboxes in request order.
// RL21 - abort empties pending or scheduled at once, transmit one at its end.
// RL22 - no-retransmit attempts once and flags complete with outcome.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "cmtx_consts.vh"

module cmtx_ctrl #(
	parameter IDLE_BITS = `CMTX_IDLE_BITS
) (
	// clock, reset, enable
	input  wire       i_clk_sys,
	input  wire       i_rstn,
	input  wire       i_ce,
	// register port
	input  wire [7:0] i_addr,
	input  wire [7:0] i_wdata,
	input  wire       i_wr,
	input  wire       i_rd,
	output reg  [7:0] o_rdata,
	// bus pins
	input  wire       i_rx_pin,
	output reg        o_tx_pin,
	// protocol core side
	input  wire       i_bit_tick,
	input  wire       i_core_tx,
	output reg        o_core_rx,
	output reg        o_core_en,
	output reg        o_ack_err_ign,
	output reg        o_tx_start,
	output reg        o_tx_mbox,
	input  wire       i_tx_done,
	input  wire       i_tx_ok,
	input  wire       i_tx_arbitration_lost_flag,
	input  wire       i_tx_transmit_error_flag,
	input  wire [3:0] i_core_idx,
	output reg  [7:0] o_core_byte,
	// wake-up interrupt
	output reg        o_wkup_irq
);

	// mode states
	localparam [1:0] M_SLEEP = 2'h0;
	localparam [1:0] M_INIT  = 2'h1;
	localparam [1:0] M_SYNC  = 2'h2;
	localparam [1:0] M_NORM  = 2'h3;

	reg  [1:0] mode_q;
	reg  [7:0] mcr_q;
	reg  [1:0] ack_q;
	reg        wkui_q;
	reg        ier_q;
	reg  [1:0] dgr_q;
	reg  [7:0] tsr_q;
	reg  [1:0] st_q [0:1];
	reg  [1:0] abrt_q;
	reg        first_q;
	reg  [7:0] mem_q [0:31];
	reg        sync_clr_q;
	wire       rx_s;
	wire       idle;
	wire       busy;
	wire [1:0] want;
	wire       win;
	wire       silent;
	wire       loop;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// mailbox byte decode: returns {hit, mailbox, offset}
	function [5:0] mb_dec;
		input [7:0] a;
		begin
			if (a[7:4] == `CMTX_MB0_BASE >> 4 && a[3:0] <= `CMTX_MB_LAST) begin
				mb_dec = {2'b10, a[3:0]};
			end else if (a[7:4] == `CMTX_MB1_BASE >> 4 && a[3:0] <= `CMTX_MB_LAST) begin
				mb_dec = {2'b11, a[3:0]};
			end else begin
				mb_dec = 6'h00;
			end
		end
	endfunction

	// standard identifier of a mailbox
	function [10:0] mb_id;
		input [7:0] hi;
		input [7:0] lo;
		begin
			mb_id = {hi, lo[7:5]};
		end
	endfunction

	wire [5:0]  wdec = mb_dec(i_addr);
	wire [10:0] id0  = mb_id(mem_q[0], mem_q[1]);
	wire [10:0] id1  = mb_id(mem_q[16], mem_q[17]);

	assign silent = dgr_q[`CMTX_DGR_SILENT_SELECT_BIT];
	assign loop   = dgr_q[`CMTX_DGR_LOOPBACK_SELECT_BIT];
	assign busy   = (st_q[0] == `CMTX_MB_XMIT) || (st_q[1] == `CMTX_MB_XMIT);

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser and bus idle detection

	cmtx_sync3 #(
		.RST_VAL (1'b1)
	) u_rx_sync (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_ce      (i_ce),
		.i_async   (i_rx_pin),
		.o_level   (rx_s)
	);

	cmtx_idle_det #(
		.IDLE_BITS (IDLE_BITS)
	) u_idle (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_ce      (i_ce),
		.i_clr     (sync_clr_q),
		.i_tick    (i_bit_tick),
		.i_bit     (o_core_rx),
		.o_idle    (idle)
	);

	////////////////////////////////////////////////////////////////////////
	// scheduler: which mailboxes compete, and the winner

	assign want[0] = (st_q[0] == `CMTX_MB_PEND) || (st_q[0] == `CMTX_MB_SCHED);
	assign want[1] = (st_q[1] == `CMTX_MB_PEND) || (st_q[1] == `CMTX_MB_SCHED);
	// request order or lowest identifier, ties to mailbox zero
	assign win = (want == 2'b10) ? 1'b1 :
	             (want == 2'b01) ? 1'b0 :
	             mcr_q[`CMTX_MCR_TRANSMIT_FIFO_PRIORITY_BIT] ? first_q :  // see RL20
	             (id1 < id0);                       // see RL19

	////////////////////////////////////////////////////////////////////////
	// mode control

	// sleep, init, sync and normal with their acknowledges
	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			mode_q     <= M_SLEEP;  // see RL1
			ack_q      <= 2'b10;
			sync_clr_q <= 1'b0;
		end else if (i_ce) begin
			sync_clr_q <= 1'b0;
			case (mode_q)
				// clock stopped: status frozen until the sleep request clears
				M_SLEEP: begin
					if (!mcr_q[`CMTX_MCR_SLRQ]) begin  // see RL8
						mode_q     <= M_SYNC;
						sync_clr_q <= 1'b1;
					end
				end
				M_INIT: begin
					if (mcr_q[`CMTX_MCR_INIT_REQUEST_BIT]) begin
						ack_q <= 2'b01;
					end else if (mcr_q[`CMTX_MCR_SLRQ]) begin
						mode_q <= M_SLEEP;
						ack_q  <= 2'b10;
					end else begin
						mode_q     <= M_SYNC;  // see RL4
						sync_clr_q <= 1'b1;
					end
				end
				// acknowledges clear to normal only after the bus was seen idle; an init request acknowledges init at once
				M_SYNC: begin
					if (mcr_q[`CMTX_MCR_INIT_REQUEST_BIT]) begin
						mode_q <= M_INIT;
						ack_q  <= 2'b01;
					end else if (idle) begin
						mode_q <= M_NORM;  // see RL3
						ack_q  <= 2'b00;   // see RL11
					end
				end
				// leave normal only between frames
				default: begin
					if (mcr_q[`CMTX_MCR_INIT_REQUEST_BIT] && !busy) begin
						mode_q <= M_INIT;  // see RL2
						ack_q  <= 2'b01;
					end else if (mcr_q[`CMTX_MCR_SLRQ] && !busy) begin
						mode_q <= M_SLEEP;  // see RL2
						ack_q  <= 2'b10;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin and core routing for test modes

	// transfers and pin drive depend on mode and diagnostic bits
	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_tx_pin      <= 1'b1;
			o_core_rx     <= 1'b1;
			o_core_en     <= 1'b0;
			o_ack_err_ign <= 1'b0;
		end else if (i_ce) begin
			o_core_en     <= (mode_q == M_NORM);  // see RL12
			o_ack_err_ign <= loop;               // see RL14
			if (mode_q != M_NORM || silent) begin
				o_tx_pin <= 1'b1;  // see RL5 see RL13 see RL15
			end else begin
				o_tx_pin <= i_core_tx;  // see RL14
			end
			if (loop) begin
				o_core_rx <= i_core_tx;  // see RL14 see RL15
			end else if (silent) begin
				o_core_rx <= rx_s & i_core_tx;  // see RL13
			end else begin
				o_core_rx <= rx_s;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers; a mode change never touches them

	// master control, interrupt enable, diagnostic and wake-up flag
	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			mcr_q  <= `CMTX_MCR_RST;
			ier_q  <= 1'b0;
			dgr_q  <= 2'h0;
			wkui_q <= 1'b0;
			o_wkup_irq <= 1'b0;
		end else if (i_ce) begin
			if (i_wr && i_addr == `CMTX_MCR_OFS) begin
				mcr_q <= i_wdata;  // see RL6
			end else if (i_wr && i_addr == `CMTX_IER_OFS) begin
				ier_q <= i_wdata[`CMTX_IER_WAKEUP_INTERRUPT_ENABLE];
			end else if (i_wr && i_addr == `CMTX_DGR_OFS && mode_q == M_INIT) begin
				dgr_q <= i_wdata[1:0];  // see RL12
			end
			if (i_wr && i_addr == `CMTX_MSR_OFS && i_wdata[`CMTX_MSR_WKUI]) begin
				wkui_q <= 1'b0;
			end
			// bus activity in sleep; the set wins over a clear
			if (mode_q == M_SLEEP && !rx_s) begin
				wkui_q <= 1'b1;
				if (mcr_q[`CMTX_MCR_AUTO_WAKEUP_BIT]) begin
					mcr_q[`CMTX_MCR_SLRQ] <= 1'b0;  // see RL9
				end
			end
			o_wkup_irq <= wkui_q & ier_q;  // see RL10
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mailbox storage; writes only while the mailbox is empty

	integer k;
	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			for (k = 0; k < 32; k = k + 1) begin
				mem_q[k] <= 8'h00;
			end
			o_core_byte <= 8'h00;
		end else if (i_ce) begin
			if (i_wr && wdec[5] && st_q[wdec[4]] == `CMTX_MB_EMPTY) begin
				mem_q[wdec[4:0]] <= i_wdata;  // see RL16
			end
			o_core_byte <= mem_q[{o_tx_mbox, i_core_idx}];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mailbox state machines and transmit status flags

	integer n;
	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			st_q[0]    <= `CMTX_MB_EMPTY;
			st_q[1]    <= `CMTX_MB_EMPTY;
			abrt_q     <= 2'b00;
			tsr_q      <= 8'h00;
			first_q    <= 1'b0;
			o_tx_start <= 1'b0;
			o_tx_mbox  <= 1'b0;
		end else if (i_ce) begin
			o_tx_start <= 1'b0;
			// software clears flags by writing ones; sets below win
			if (i_wr && i_addr == `CMTX_TSR_OFS) begin
				tsr_q <= tsr_q & ~i_wdata;
			end
			for (n = 0; n < 2; n = n + 1) begin
				case (st_q[n])
					`CMTX_MB_EMPTY: begin
						if (i_wr && i_addr == `CMTX_MB0_CS_OFS + n[7:0]
						    && i_wdata[`CMTX_CS_TRANSMIT_REQUEST_BIT]) begin
							st_q[n] <= `CMTX_MB_PEND;  // see RL17
							if (st_q[1 - n] == `CMTX_MB_EMPTY) begin
								first_q <= n[0];  // see RL20
							end
						end
					end
					`CMTX_MB_PEND, `CMTX_MB_SCHED: begin
						if (i_wr && i_addr == `CMTX_MB0_CS_OFS + n[7:0]
						    && i_wdata[`CMTX_CS_ABORT_REQUEST_BIT]) begin
							st_q[n] <= `CMTX_MB_EMPTY;  // see RL21
							tsr_q[4*n + `CMTX_TSR_REQUEST_COMPLETE_FLAG] <= 1'b1;
							tsr_q[4*n + `CMTX_TSR_TRANSMIT_OK_FLAG] <= 1'b0;
						end else if (win != n[0]) begin
							st_q[n] <= `CMTX_MB_PEND;
						// a pending mode request holds the start, so no frame begins as normal is left;
						// combined self-test still sends, only into the loop
						end else if (mode_q == M_NORM && (!silent || loop) && !busy && idle
						             && !mcr_q[`CMTX_MCR_INIT_REQUEST_BIT] && !mcr_q[`CMTX_MCR_SLRQ]
						             && st_q[n] == `CMTX_MB_SCHED) begin
							st_q[n]    <= `CMTX_MB_XMIT;  // see RL17 see RL13 see RL15
							o_tx_start <= 1'b1;
							o_tx_mbox  <= n[0];
						end else begin
							st_q[n] <= `CMTX_MB_SCHED;  // see RL17
						end
					end
					default: begin
						if (i_wr && i_addr == `CMTX_MB0_CS_OFS + n[7:0]
						    && i_wdata[`CMTX_CS_ABORT_REQUEST_BIT]) begin
							abrt_q[n] <= 1'b1;
						end
						if (i_tx_done && o_tx_mbox == n[0]) begin
							tsr_q[4*n + `CMTX_TSR_TRANSMIT_OK_FLAG] <= i_tx_ok;
							tsr_q[4*n + `CMTX_TSR_ARBITRATION_LOST_FLAG] <= i_tx_arbitration_lost_flag;  // see RL18
							tsr_q[4*n + `CMTX_TSR_TRANSMIT_ERROR_FLAG] <= i_tx_transmit_error_flag;  // see RL18
							if (i_tx_ok || abrt_q[n] || mcr_q[`CMTX_MCR_NO_AUTO_RETRANSMIT_BIT]) begin
								st_q[n]   <= `CMTX_MB_EMPTY;  // see RL21 see RL22
								abrt_q[n] <= 1'b0;
								tsr_q[4*n + `CMTX_TSR_REQUEST_COMPLETE_FLAG] <= 1'b1;  // see RL17
							end else begin
								st_q[n] <= `CMTX_MB_SCHED;
							end
						end
					end
				endcase
			end
			// oldest request moves on only once its mailbox empties; a retry keeps it first
			if (st_q[first_q] == `CMTX_MB_XMIT && i_tx_done
			    && (i_tx_ok || abrt_q[first_q] || mcr_q[`CMTX_MCR_NO_AUTO_RETRANSMIT_BIT])) begin  // see RL20
				first_q <= ~first_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port: data stand the cycle after the strobe

	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_rdata <= 8'h00;
		end else if (i_ce) begin
			if (!i_rd) begin
				o_rdata <= 8'h00;
			end else if (i_addr == `CMTX_MCR_OFS) begin
				o_rdata <= mcr_q;
			end else if (i_addr == `CMTX_MSR_OFS) begin
				o_rdata <= {4'h0, wkui_q, 1'b0, ack_q};
			end else if (i_addr == `CMTX_TSR_OFS) begin
				o_rdata <= tsr_q;
			end else if (i_addr == `CMTX_MB0_CS_OFS) begin
				o_rdata <= {4'h0, st_q[0], abrt_q[0], st_q[0] != `CMTX_MB_EMPTY};
			end else if (i_addr == `CMTX_MB1_CS_OFS) begin
				o_rdata <= {4'h0, st_q[1], abrt_q[1], st_q[1] != `CMTX_MB_EMPTY};
			end else if (i_addr == `CMTX_IER_OFS) begin
				o_rdata <= {7'h00, ier_q};
			end else if (i_addr == `CMTX_DGR_OFS) begin
				o_rdata <= {6'h00, dgr_q};
			end else if (wdec[5]) begin
				o_rdata <= mem_q[wdec[4:0]];
			end else begin
				o_rdata <= 8'h00;
			end
		end
	end

endmodule // cmtx_ctrl
`default_nettype wire

// file: testbench/cmtx_ctrl_monitor.sv
// cmtx_ctrl_monitor.sv: port checks of the can mode and transmit mailbox block.
// assumes i_ce held high and one bit tick per bit time.
`timescale 1ns/1ps
`default_nettype none

module cmtx_ctrl_monitor #(
	parameter IDLE_BITS = 11
) (
	// clock and reset
	input wire       i_clk_sys,
	input wire       i_rstn,
	// register port
	input wire       i_wr,
	input wire       i_rd,
	input wire [7:0] o_rdata,
	// pins and core side
	input wire       i_rx_pin,
	input wire       o_tx_pin,
	input wire       i_bit_tick,
	input wire       i_core_tx,
	input wire       o_core_rx,
	input wire       o_core_en,
	input wire       o_tx_start,
	input wire       o_tx_mbox,
	input wire       i_tx_done,
	input wire       o_wkup_irq
);
	logic [3:0] rec_q;  // recessive ticks in a row, saturating
	logic [3:0] age_q;  // cycles since a dominant pin, saturating
	logic       busy_q; // frame attempt under way

	////////////////////////////////////////////////////////////////////////////////
	// helper counters
	always @(posedge i_clk_sys) begin
		if (!i_rstn || (i_bit_tick && !o_core_rx))
			rec_q <= 4'h0;
		else if (i_bit_tick && rec_q != 4'hf)
			rec_q <= rec_q + 4'h1;
		if (!i_rstn || !i_rx_pin)
			age_q <= 4'h0;
		else if (age_q != 4'hf)
			age_q <= age_q + 4'h1;
		if (!i_rstn || i_tx_done)
			busy_q <= 1'b0;
		else if (o_tx_start)
			busy_q <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	sequence s_pulse;
		o_tx_start ##1 !o_tx_start;
	endsequence
	sequence s_quiet;
		!o_core_en [*2];
	endsequence

	reset_state_a: assert property (disable iff (1'b0)
		!i_rstn |=> o_tx_pin && o_core_rx && !o_core_en && !o_tx_start)
		else $error("outputs wrong under reset");
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read slot");
	start_pulse_a: assert property (o_tx_start |-> s_pulse)
		else $error("start longer than one cycle");
	start_allowed_a: assert property (o_tx_start |-> o_core_en && !busy_q)
		else $error("start outside normal mode or during a frame");
	mbox_steady_a: assert property ($changed(o_tx_mbox) |-> o_tx_start)
		else $error("mailbox select moved without start");
	idle_recessive_a: assert property (s_quiet |-> o_tx_pin)
		else $error("transmit pin dominant while core stopped");
	tx_follows_core_a: assert property (!o_tx_pin |-> !$past(i_core_tx))
		else $error("dominant pin without dominant core bit");
	sync_first_a: assert property (
		$rose(o_core_en) |-> rec_q >= IDLE_BITS - 1)
		else $error("core enabled before bus idle");
	wake_cause_a: assert property (
		$rose(o_wkup_irq) |-> age_q < 4'ha || $past(i_wr, 2))
		else $error("wake interrupt without bus activity");
	start_seen_c: cover property (o_tx_start);
endmodule // cmtx_ctrl_monitor

bind cmtx_ctrl cmtx_ctrl_monitor #(.IDLE_BITS(IDLE_BITS)) u_cmtx_ctrl_monitor (
	.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_rx_pin(i_rx_pin), .o_tx_pin(o_tx_pin), .i_bit_tick(i_bit_tick), .i_core_tx(i_core_tx),
	.o_core_rx(o_core_rx), .o_core_en(o_core_en), .o_tx_start(o_tx_start), .o_tx_mbox(o_tx_mbox),
	.i_tx_done(i_tx_done), .o_wkup_irq(o_wkup_irq));
`default_nettype wire

// file: testbench/cmtx_bus_model.sv
// cmtx_bus_model.sv: far side model, the bus seen through the protocol core.
// assumes one frame at a time; outcome and length are set by the bench.
`timescale 1ns/1ps
`default_nettype none

module cmtx_bus_model (
	// clock and reset
	input  wire       i_clk_sys,
	input  wire       i_rstn,
	// scenario controls
	input  wire       i_wake,
	input  wire [1:0] i_res,
	input  wire [7:0] i_len,
	// block side
	input  wire       i_tx_start,
	output wire       o_rx_pin,
	output wire       o_bit_tick,
	output wire       o_core_tx,
	output wire       o_tx_done,
	output wire       o_tx_ok,
	output wire       o_tx_arbitration_lost_flag,
	output wire       o_tx_transmit_error_flag,
	output wire [3:0] o_core_idx
);
	logic [1:0] tick_q = 2'h0;
	logic [7:0] cnt_q  = 8'h00;
	logic       done_q = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// bit tick every four cycles, frame length count, end of attempt pulse
	always @(posedge i_clk_sys) begin
		tick_q <= i_rstn ? tick_q + 2'h1 : 2'h0;
		done_q <= i_rstn && cnt_q == 8'h01;
		if (!i_rstn)
			cnt_q <= 8'h00;
		else if (i_tx_start)
			cnt_q <= i_len;
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
	end

	// pull-up holds the bus recessive unless another node is active
	assign o_rx_pin   = !i_wake;
	assign o_bit_tick = tick_q == 2'h3;
	// frame bits alternate while sending, recessive otherwise
	assign o_core_tx  = cnt_q == 8'h00 || cnt_q[0];
	assign o_core_idx = cnt_q[3:0];
	assign o_tx_done  = done_q;
	// outcome levels that stand beside the end pulse
	assign o_tx_ok    = i_res == 2'h0;
	assign o_tx_arbitration_lost_flag  = i_res == 2'h1;
	assign o_tx_transmit_error_flag  = i_res == 2'h2;
endmodule // cmtx_bus_model
`default_nettype wire

// file: testbench/cmtx_ctrl_test.sv
// cmtx_ctrl_test.sv: self-checking bench of the can mode and mailbox block.
// assumes the bus model on the pin and core side, clock at 25 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "cmtx_consts.vh"

module cmtx_ctrl_test;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       rd_d = 1'b0;
	logic       wake = 1'b0;
	logic [1:0] res = 2'h0;
	logic [7:0] len = 8'h10;
	logic [7:0] b;
	logic [15:0] reg_q[$];
	logic       mbx_q[$];
	integer     seed = 55;
	int         failures = 0;
	int         tests_run = 0;
	wire [7:0]  rdata, cbyte;
	wire [3:0]  idx;
	wire        rx, tx, crx, cen, start, mbox, irq, tick, ctx, done, ok, arbitration_lost_flag, transmit_error_flag, aei;

	always #20 clk = ~clk;

	cmtx_ctrl u_cmtx_ctrl (.i_clk_sys(clk), .i_rstn(rstn), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_pin(rx), .o_tx_pin(tx), .i_bit_tick(tick),
		.i_core_tx(ctx), .o_core_rx(crx), .o_core_en(cen), .o_ack_err_ign(aei), .o_tx_start(start),
		.o_tx_mbox(mbox), .i_tx_done(done), .i_tx_ok(ok), .i_tx_arbitration_lost_flag(arbitration_lost_flag), .i_tx_transmit_error_flag(transmit_error_flag),
		.i_core_idx(idx), .o_core_byte(cbyte), .o_wkup_irq(irq));
	cmtx_bus_model u_cmtx_bus_model (.i_clk_sys(clk), .i_rstn(rstn), .i_wake(wake), .i_res(res),
		.i_len(len), .i_tx_start(start), .o_rx_pin(rx), .o_bit_tick(tick), .o_core_tx(ctx),
		.o_tx_done(done), .o_tx_ok(ok), .o_tx_arbitration_lost_flag(arbitration_lost_flag), .o_tx_transmit_error_flag(transmit_error_flag), .o_core_idx(idx));

	////////////////////////////////////////////////////////////////////////////////
	// verdict, compares and bus tasks
	task automatic test_done;
		if (failures == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cmp_reg(input logic [15:0] n, input logic [7:0] v);
		if (n[15:8] != 8'h00) begin
			tests_run++;
			if ((v & n[15:8]) !== n[7:0]) begin
				failures++;
				$display("ERROR t=%0t got %h exp %h", $time, v & n[15:8], n[7:0]);
			end
		end
	endtask

	task automatic cmp_bit(input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic acc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, output logic [7:0] v);
		addr <= a;
		rd <= 1'b1;
		reg_q.push_back({m, e});
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
		@(posedge clk);
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		acc(a, 8'hff, e, v);
	endtask

	// bounded wait on a register field
	task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] v;
		for (int n = 0; n < 400; n++) begin
			acc(a, 8'h00, 8'h00, v);
			if ((v & m) === e)
				return;
		end
		failures++;
		$display("ERROR t=%0t got %h exp %h", $time, v & m, e);
		test_done();
	endtask

	// observer: read data one cycle after the strobe, mailbox at each start
	always @(posedge clk) begin
		if (rd_d)
			cmp_reg(reg_q.pop_front(), rdata);
		rd_d <= rd;
		if (start === 1'b1)
			cmp_bit(mbx_q.size() != 0 ? mbx_q.pop_front() : 1'bx, mbox);
		// at the end pulse the core has fetched byte 1, the never written low identifier byte
		if (done === 1'b1)
			cmp_reg({8'hff, 8'h00}, cbyte);
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd_reg(`CMTX_MCR_OFS, `CMTX_MCR_RST);
		rd_reg(`CMTX_MSR_OFS, 8'h02);
		rd_reg(8'h3f, 8'h00);
		wr_reg(`CMTX_MCR_OFS, 8'h03);
		rd_reg(`CMTX_MSR_OFS, 8'h02);
		// bus activity wakes the block with auto wake and interrupt on
		wr_reg(`CMTX_IER_OFS, 8'h01);
		wr_reg(`CMTX_MCR_OFS, 8'h23);
		wake <= 1'b1;
		poll(`CMTX_MSR_OFS, 8'h08, 8'h08);
		wake <= 1'b0;
		rd_reg(`CMTX_MCR_OFS, 8'h21);
		cmp_bit(1'b1, irq);
		poll(`CMTX_MSR_OFS, 8'h0b, 8'h09);
		wr_reg(`CMTX_MSR_OFS, 8'h08);
		rd_reg(`CMTX_MSR_OFS, 8'h01);
		// silent mode holds a request scheduled, abort empties it
		wr_reg(`CMTX_DGR_OFS, 8'h01);
		rd_reg(`CMTX_DGR_OFS, 8'h01);
		wr_reg(`CMTX_MCR_OFS, 8'h20);
		rd_reg(`CMTX_MSR_OFS, 8'h01);
		poll(`CMTX_MSR_OFS, 8'h03, 8'h00);
		wr_reg(`CMTX_DGR_OFS, 8'h00);
		rd_reg(`CMTX_DGR_OFS, 8'h01);
		wr_reg(`CMTX_MB0_CS_OFS, 8'h01);
		rd_reg(`CMTX_TSR_OFS, 8'h00);
		rd_reg(`CMTX_MB0_CS_OFS, 8'h09);
		wr_reg(`CMTX_MB0_CS_OFS, 8'h02);
		rd_reg(`CMTX_MB0_CS_OFS, 8'h00);
		rd_reg(`CMTX_TSR_OFS, 8'h01);
		wr_reg(`CMTX_TSR_OFS, 8'hff);
		wr_reg(`CMTX_MCR_OFS, 8'h21);
		poll(`CMTX_MSR_OFS, 8'h03, 8'h01);
		rd_reg(`CMTX_IER_OFS, 8'h01);
		// identifier order, equal identifiers, request order; plain, loop-back, combined test
		for (int k = 0; k < 3; k++) begin
			b = 8'($random(seed)) & 8'hfe;
			wr_reg(`CMTX_MCR_OFS, k == 2 ? 8'h25 : 8'h21);
			wr_reg(`CMTX_DGR_OFS, {6'h00, k != 0, k == 2});
			wr_reg(`CMTX_MB0_BASE, k == 0 ? b + 8'h01 : b);
			wr_reg(`CMTX_MB1_BASE, b);
			wr_reg(k == 2 ? `CMTX_MB1_CS_OFS : `CMTX_MB0_CS_OFS, 8'h01);
			wr_reg(k == 2 ? `CMTX_MB0_CS_OFS : `CMTX_MB1_CS_OFS, 8'h01);
			wr_reg(`CMTX_MB1_BASE, ~b);
			rd_reg(`CMTX_MB1_BASE, b);
			cmp_bit(k != 0, aei);
			mbx_q.push_back(k != 1);
			mbx_q.push_back(k == 1);
			wr_reg(`CMTX_MCR_OFS, k == 2 ? 8'h24 : 8'h20);
			poll(`CMTX_TSR_OFS, 8'hff, 8'h33);
			wr_reg(`CMTX_TSR_OFS, 8'hff);
			wr_reg(`CMTX_MCR_OFS, 8'h21);
			poll(`CMTX_MSR_OFS, 8'h03, 8'h01);
		end
		// single attempt that loses arbitration
		res <= 2'h1;
		wr_reg(`CMTX_MCR_OFS, 8'h30);
		mbx_q.push_back(1'b0);
		wr_reg(`CMTX_MB0_CS_OFS, 8'h01);
		poll(`CMTX_TSR_OFS, 8'h0f, 8'h05);
		rd_reg(`CMTX_MB0_CS_OFS, 8'h00);
		wr_reg(`CMTX_TSR_OFS, 8'hff);
		// abort during a frame that then fails
		res <= 2'h2;
		len <= 8'h40;
		wr_reg(`CMTX_MCR_OFS, 8'h20);
		mbx_q.push_back(1'b0);
		wr_reg(`CMTX_MB0_CS_OFS, 8'h01);
		poll(`CMTX_MB0_CS_OFS, 8'h0c, 8'h0c);
		wr_reg(`CMTX_MB0_CS_OFS, 8'h02);
		poll(`CMTX_TSR_OFS, 8'h0f, 8'h09);
		rd_reg(`CMTX_MB0_CS_OFS, 8'h00);
		repeat (2) @(posedge clk);
		test_done();
	end
endmodule // cmtx_ctrl_test
`default_nettype wire
